// ---- enable_output_config_decode.sv ----
`timescale 1ns/1ps

// Contract
// - output 1 decodes bits 2:0 of the first byte as open-drain or push-pull, active low or active high.
// - on outputs 1 to 4 code 100 selects closed-loop tracking instead of plain enable signalling.
// - on outputs 1 to 6 code 101 selects charge-pump drive toward the paired monitor input plus 5V.
// - output 2 takes its code from bits 5:3 of the first byte with the same meanings.
// - output 3 takes its low two bits from first-byte bits 7:6 and its top bit from second-byte bit 0.
// - output 4 takes its code from bits 3:1 of the second byte, tracking and pump included.
// - output 5 takes bits 6:4 of the second byte and code 100 is reserved with no tracking.
// - output 6 takes its low bit from second-byte bit 7 and top bits from third-byte bits 1:0, 100 reserved.
// - outputs 7 to 12 decode two-bit fields in third-byte bits 3:2, 5:4, 7:6 and fourth-byte 1:0, 3:2, 5:4.
// - a build parameter picks twelve or eight outputs, and fields 9 to 12 do nothing with eight.
// - after reset and before any request each output sits at the deasserted level of its mode.
module enable_output_config_decode
  import enable_output_cfg_pkg::*;
#(
  parameter int NUM_OUT = 12
) (
  // clock and reset
  input  wire logic                                clk_sys,
  input  wire logic                                rst,
  // register port from the serial host interface
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  input  wire logic [7:0]                          reg_addr,
  input  wire logic [7:0]                          reg_wdata,
  output logic      [7:0]                          reg_rdata,
  // assert requests from the sequencer
  input  wire logic [enable_output_cfg_pkg::MAX_OUT-1:0] assert_req,
  // enable output pins
  output logic      [enable_output_cfg_pkg::MAX_OUT-1:0] pin_out,
  output logic      [enable_output_cfg_pkg::MAX_OUT-1:0] pin_oe_n,
  // analog mode controls
  output logic      [enable_output_cfg_pkg::MAX_OUT-1:0] track_en,
  output logic      [enable_output_cfg_pkg::MAX_OUT-1:0] pump_en
);
  import enable_output_cfg_pkg::*;

  logic [7:0]         cfg_a_q, cfg_a_d;
  logic [7:0]         cfg_b_q, cfg_b_d;
  logic [7:0]         cfg_c_q, cfg_c_d;
  logic [7:0]         cfg_d_q, cfg_d_d;
  logic [7:0]         rdata_q, rdata_d;
  logic [MAX_OUT-1:0] out_q, out_d;
  logic [MAX_OUT-1:0] oe_n_q, oe_n_d;
  logic [MAX_OUT-1:0] track_q, track_d;
  logic [MAX_OUT-1:0] pump_q, pump_d;
  logic [2:0]         code_w [MAX_OUT];

  // register writes and registered read data
  always_comb begin
    cfg_a_d = cfg_a_q;
    cfg_b_d = cfg_b_q;
    cfg_c_d = cfg_c_q;
    cfg_d_d = cfg_d_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      if (reg_addr == OFS_CFG_A) begin
        cfg_a_d = reg_wdata;
      end else if (reg_addr == OFS_CFG_B) begin
        cfg_b_d = reg_wdata;
      end else if (reg_addr == OFS_CFG_C) begin
        cfg_c_d = reg_wdata;
      end else if (reg_addr == OFS_CFG_D) begin
        cfg_d_d = reg_wdata & CFG_D_MASK; // reserved top bits
      end
    end
    if (reg_rd) begin
      if (reg_addr == OFS_CFG_A) begin
        rdata_d = cfg_a_q;
      end else if (reg_addr == OFS_CFG_B) begin
        rdata_d = cfg_b_q;
      end else if (reg_addr == OFS_CFG_C) begin
        rdata_d = cfg_c_q;
      end else if (reg_addr == OFS_CFG_D) begin
        rdata_d = cfg_d_q;
      end else begin
        rdata_d = RDATA_NONE; // unmapped offset
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_a_q <= CFG_RESET;
      cfg_b_q <= CFG_RESET;
      cfg_c_q <= CFG_RESET;
      cfg_d_q <= CFG_RESET;
      rdata_q <= RDATA_NONE;
    end else begin
      cfg_a_q <= cfg_a_d;
      cfg_b_q <= cfg_b_d;
      cfg_c_q <= cfg_c_d;
      cfg_d_q <= cfg_d_d;
      rdata_q <= rdata_d;
    end
  end

  // field extraction, two-bit fields padded to three with a zero top bit
  assign code_w[0]  = cfg_a_q[POS_OUT1 +: 3];
  assign code_w[1]  = cfg_a_q[POS_OUT2 +: 3];
  assign code_w[2]  = {cfg_b_q[POS_OUT3_HI], cfg_a_q[POS_OUT3_LO +: 2]};
  assign code_w[3]  = cfg_b_q[POS_OUT4 +: 3];
  assign code_w[4]  = cfg_b_q[POS_OUT5 +: 3];
  assign code_w[5]  = {cfg_c_q[POS_OUT6_HI +: 2], cfg_b_q[POS_OUT6_LO]};
  assign code_w[6]  = {1'b0, cfg_c_q[POS_OUT7 +: 2]};
  assign code_w[7]  = {1'b0, cfg_c_q[POS_OUT8 +: 2]};
  assign code_w[8]  = {1'b0, cfg_c_q[POS_OUT9 +: 2]};
  assign code_w[9]  = {1'b0, cfg_d_q[POS_OUT10 +: 2]};
  assign code_w[10] = {1'b0, cfg_d_q[POS_OUT11 +: 2]};
  assign code_w[11] = {1'b0, cfg_d_q[POS_OUT12 +: 2]};

  // per-output mode decode and pin drive
  always_comb begin
    logic [2:0] c;
    logic       lvl;
    c       = CODE_OD_LOW;
    lvl     = 1'b0;
    out_d   = '0;
    oe_n_d  = '1;
    track_d = '0;
    pump_d  = '0;
    for (int i = 0; i < MAX_OUT; i++) begin
      c   = code_w[i];
      lvl = assert_req[i] ~^ c[BIT_HIGH]; // level follows polarity
      if (i >= NUM_OUT) begin
        oe_n_d[i] = 1'b1;
      end else if (!c[BIT_SPEC]) begin
        out_d[i]  = lvl;
        oe_n_d[i] = c[BIT_PP] ? 1'b0 : lvl;
      end else if (c == CODE_TRACK && i < TRACK_OUT) begin
        track_d[i] = assert_req[i];
        oe_n_d[i]  = assert_req[i]; // gate held low until the loop takes over
      end else if (c == CODE_PUMP && i < PUMP_OUT) begin
        pump_d[i]  = assert_req[i];
        oe_n_d[i]  = assert_req[i];
      end else begin
        oe_n_d[i] = 1'b1;
      end
    end
  end

  // pins start released and reach the decoded level one edge after reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_q   <= '0;
      oe_n_q  <= '1;
      track_q <= '0;
      pump_q  <= '0;
    end else begin
      out_q   <= out_d;
      oe_n_q  <= oe_n_d;
      track_q <= track_d;
      pump_q  <= pump_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pin_out   = out_q;
  assign pin_oe_n  = oe_n_q;
  assign track_en  = track_q;
  assign pump_en   = pump_q;

  // checks on decoded drive
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_out1_push_high: assert property ((code_w[0] == CODE_PP_HIGH && assert_req[0]) |=>
    (pin_out[0] && !pin_oe_n[0])) else $error("output 1 push-pull high not driven high");
  chk_out2_track_mode: assert property ((code_w[1] == CODE_TRACK && assert_req[1]) |=>
    (track_en[1] && !pump_en[1])) else $error("output 2 tracking not enabled");
  chk_out1_pump_mode: assert property ((cfg_a_q[2:0] == CODE_PUMP && assert_req[0]) |=>
    (pump_en[0] && !track_en[0] && pin_oe_n[0])) else $error("output 1 pump not enabled");
  chk_out2_pump_field: assert property ((cfg_a_q[5:3] == CODE_PUMP && assert_req[1]) |=>
    pump_en[1]) else $error("output 2 pump field misread");
  chk_out3_split_field: assert property (({cfg_b_q[0], cfg_a_q[7:6]} == CODE_PP_LOW && assert_req[2]) |=>
    (!pin_out[2] && !pin_oe_n[2])) else $error("output 3 split field misread");
  chk_out4_od_idle: assert property ((cfg_b_q[3:1] == CODE_OD_HIGH && !assert_req[3]) |=>
    (!pin_out[3] && !pin_oe_n[3])) else $error("output 4 open-drain high idle not low");
  chk_out5_no_track: assert property ((cfg_b_q[6:4] == CODE_TRACK) |=>
    (!track_en[4] && pin_oe_n[4])) else $error("output 5 reserved code tracked");
  chk_out6_no_track: assert property (({cfg_c_q[1:0], cfg_b_q[7]} == CODE_TRACK) |=>
    (!track_en[5] && pin_oe_n[5])) else $error("output 6 reserved code tracked");
  chk_out7_od_low: assert property ((cfg_c_q[3:2] == 2'h0 && assert_req[6]) |=>
    (!pin_out[6] && !pin_oe_n[6])) else $error("output 7 open-drain low not pulled");
  chk_small_variant: assert property ((NUM_OUT > 8) || (&pin_oe_n[11:8] && ~|track_en[11:8]))
    else $error("unused outputs driven in eight-output build");
  chk_reserved_idle: assert property ((code_w[0] == CODE_RSVD) |=>
    (pin_oe_n[0] && !pump_en[0] && !track_en[0])) else $error("reserved code drives output 1");
  chk_od_release: assert property ((code_w[7] == CODE_OD_HIGH) |=>
    (pin_oe_n[7] == $past(assert_req[7]) && pin_out[7] == $past(assert_req[7]))) else $error("open-drain release mismatch");

  // special modes, idle gates and the upper fields
  chk_out6_pump_mode: assert property (({cfg_c_q[1:0], cfg_b_q[7]} == CODE_PUMP && assert_req[5]) |=>
    (pump_en[5] && pin_oe_n[5])) else $error("output 6 pump not enabled");
  chk_out5_pump_mode: assert property ((cfg_b_q[6:4] == CODE_PUMP && assert_req[4]) |=>
    (pump_en[4] && !track_en[4])) else $error("output 5 pump not enabled");
  chk_out4_track_field: assert property ((cfg_b_q[3:1] == CODE_TRACK && assert_req[3]) |=>
    (track_en[3] && pin_oe_n[3])) else $error("output 4 tracking field misread");
  chk_out2_pump_idle: assert property ((cfg_a_q[5:3] == CODE_PUMP && !assert_req[1]) |=>
    (!pump_en[1] && !pin_oe_n[1] && !pin_out[1])) else $error("output 2 idle pump gate not held low");
  chk_out1_track_idle: assert property ((cfg_a_q[2:0] == CODE_TRACK && !assert_req[0]) |=>
    (!track_en[0] && !pin_oe_n[0] && !pin_out[0])) else $error("output 1 idle tracking gate not held low");
  chk_out3_track_idle: assert property (({cfg_b_q[0], cfg_a_q[7:6]} == CODE_TRACK && !assert_req[2]) |=>
    (!track_en[2] && !pin_oe_n[2])) else $error("output 3 tracking field misread");
  chk_special_range: assert property (~|pump_en[MAX_OUT-1:PUMP_OUT] && ~|track_en[MAX_OUT-1:TRACK_OUT])
    else $error("special mode on an output that lacks it");
  chk_cfg_d_mask: assert property (cfg_d_q[7:6] == 2'h0)
    else $error("reserved bits of fourth byte stored");
  chk_out9_od_idle: assert property ((NUM_OUT > 8 && cfg_c_q[7:6] == 2'h1 && !assert_req[8]) |=>
    (!pin_out[8] && !pin_oe_n[8])) else $error("output 9 open-drain high idle not low");
  chk_out12_pp_high: assert property ((NUM_OUT == 12 && cfg_d_q[5:4] == 2'h3 && assert_req[11]) |=>
    (pin_out[11] && !pin_oe_n[11])) else $error("output 12 push-pull high not driven high");

  cov_pump_on: cover property (pump_en[0] ##1 !pump_en[0]);
  cov_track_on: cover property (track_en[3]);
  cov_pp_high_out9: cover property (cfg_c_q[7:6] == 2'h3 && assert_req[8] ##1 pin_out[8]);
  cov_out8_od_release: cover property (code_w[7] == CODE_OD_HIGH && assert_req[7] ##1 pin_oe_n[7]);
  cov_out6_reserved: cover property ({cfg_c_q[1:0], cfg_b_q[7]} == CODE_TRACK ##1 pin_oe_n[5]);

endmodule // enable_output_config_decode

// ---- enable_output_cfg_pkg.sv ----
package enable_output_cfg_pkg;

  // register offsets on the host register port
  localparam logic [7:0] OFS_CFG_A = 8'h1f;
  localparam logic [7:0] OFS_CFG_B = 8'h20;
  localparam logic [7:0] OFS_CFG_C = 8'h21;
  localparam logic [7:0] OFS_CFG_D = 8'h22;

  // reset value of every configuration byte: open-drain active-low
  localparam logic [7:0] CFG_RESET  = 8'h00;
  // writable bits of the fourth byte; bits 7:6 read as zero
  localparam logic [7:0] CFG_D_MASK = 8'h3f;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // output counts
  localparam int MAX_OUT   = 12;
  localparam int TRACK_OUT = 4;
  localparam int PUMP_OUT  = 6;
  localparam int WIDE_OUT  = 6;

  // field positions (low bit of each field)
  localparam int POS_OUT1     = 0;
  localparam int POS_OUT2     = 3;
  localparam int POS_OUT3_LO  = 6;
  localparam int POS_OUT3_HI  = 0;
  localparam int POS_OUT4     = 1;
  localparam int POS_OUT5     = 4;
  localparam int POS_OUT6_LO  = 7;
  localparam int POS_OUT6_HI  = 0;
  localparam int POS_OUT7     = 2;
  localparam int POS_OUT8     = 4;
  localparam int POS_OUT9     = 6;
  localparam int POS_OUT10    = 0;
  localparam int POS_OUT11    = 2;
  localparam int POS_OUT12    = 4;

  // mode codes
  localparam logic [2:0] CODE_OD_LOW  = 3'h0;
  localparam logic [2:0] CODE_OD_HIGH = 3'h1;
  localparam logic [2:0] CODE_PP_LOW  = 3'h2;
  localparam logic [2:0] CODE_PP_HIGH = 3'h3;
  localparam logic [2:0] CODE_TRACK   = 3'h4;
  localparam logic [2:0] CODE_PUMP    = 3'h5;
  localparam logic [2:0] CODE_RSVD    = 3'h6;

  // bit meanings inside a plain enable code
  localparam int BIT_HIGH = 0;
  localparam int BIT_PP   = 1;
  localparam int BIT_SPEC = 2;

endpackage

// ---- enable_pin_load.sv ----
`timescale 1ns/1ps

// far-side load: a pull-up on every enable line, so a released line reads high
module enable_pin_load
  import enable_output_cfg_pkg::*;
(
  // driver side of the enable lines
  input  wire logic [enable_output_cfg_pkg::MAX_OUT-1:0] pin_out,
  input  wire logic [enable_output_cfg_pkg::MAX_OUT-1:0] pin_oe_n,
  // level seen by the supply enable inputs
  output logic      [enable_output_cfg_pkg::MAX_OUT-1:0] wire_level
);
  // resolve each line from drive enable and the pull-up
  always_comb begin
    for (int i = 0; i < MAX_OUT; i++) wire_level[i] = pin_oe_n[i] ? 1'b1 : pin_out[i];
  end
endmodule // enable_pin_load

// ---- tb_enable_output_config_decode.sv ----
`timescale 1ns/1ps

module tb_enable_output_config_decode;
  import enable_output_cfg_pkg::*;
  typedef logic [MAX_OUT-1:0] vec_t;
  typedef struct {logic [7:0] a; logic [7:0] b; logic [7:0] c; logic [7:0] d;
                  vec_t req; vec_t lvl; vec_t oen; vec_t trk; vec_t pmp;} row_t;
  logic       clk_sys, rst, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, rd12, rd8;
  vec_t       assert_req, out12, oen12, trk12, pmp12, lvl12, out8, oen8, trk8, pmp8, lvl8;
  int         miscompares, num_checks;
  // config bytes and request beside expected wire level, drive enable, tracking and pump
  row_t rows [7] = '{
    '{8'h00, 8'h00, 8'h00, 8'h00, 12'h000, 12'hfff, 12'hfff, 12'h000, 12'h000},
    '{8'h00, 8'h00, 8'h00, 8'h00, 12'hfff, 12'h000, 12'h000, 12'h000, 12'h000},
    '{8'h63, 8'hc9, 8'he6, 8'hf4, 12'hfff, 12'hd7f, 12'h47e, 12'h00a, 12'h024},
    '{8'h63, 8'hc9, 8'he6, 8'hf4, 12'h000, 12'h290, 12'h210, 12'h000, 12'h000},
    '{8'hcd, 8'ha2, 8'h9c, 8'hdb, 12'h6a5, 12'h3b5, 12'h0a1, 12'h000, 12'h001},
    '{8'h2c, 8'h5b, 8'h72, 8'h22, 12'ha5a, 12'h43a, 12'h43a, 12'h000, 12'h01a},
    '{8'hbe, 8'he2, 8'h03, 8'h00, 12'h0ff, 12'hf3b, 12'hf3b, 12'h000, 12'h000}};

  // full and reduced builds side by side on the same inputs
  enable_output_config_decode #(.NUM_OUT(12)) dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rd12), .assert_req(assert_req),
    .pin_out(out12), .pin_oe_n(oen12), .track_en(trk12), .pump_en(pmp12));
  enable_output_config_decode #(.NUM_OUT(8)) dut_8 (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rd8), .assert_req(assert_req),
    .pin_out(out8), .pin_oe_n(oen8), .track_en(trk8), .pump_en(pmp8));
  enable_pin_load load_12 (.pin_out(out12), .pin_oe_n(oen12), .wire_level(lvl12));
  enable_pin_load load_8 (.pin_out(out8), .pin_oe_n(oen8), .wire_level(lvl8));

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic cmp(input string name, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge clk_sys);
    reg_wr    = 1'b1;
    reg_addr  = ad;
    reg_wdata = dt;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
  endtask

  // read from both builds; data is registered one edge after the strobe
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_rd   = 1'b1;
    reg_addr = ad;
    @(negedge clk_sys);
    reg_rd   = 1'b0;
    cmp("rdata", {4'h0, exp}, {4'h0, rd12});
    cmp("rdata_8", {4'h0, exp}, {4'h0, rd8});
  endtask

  // load a row, raise its request and look one edge later
  task automatic run_row(input row_t r);
    wr(OFS_CFG_A, r.a);
    wr(OFS_CFG_B, r.b);
    wr(OFS_CFG_C, r.c);
    wr(OFS_CFG_D, r.d);
    @(negedge clk_sys);
    assert_req = r.req;
    @(negedge clk_sys);
    cmp("wire_level", r.lvl, lvl12);
    cmp("pin_oe_n", r.oen, oen12);
    cmp("track_en", r.trk, trk12);
    cmp("pump_en", r.pmp, pmp12);
    cmp("wire_level_8", r.lvl | 12'hf00, lvl8);
    cmp("pin_oe_n_8", r.oen | 12'hf00, oen8);
    cmp("track_en_8", r.trk & 12'h0ff, trk8);
    cmp("pump_en_8", r.pmp & 12'h0ff, pmp8);
  endtask

  task automatic conclude;
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog well beyond the roughly one hundred cycles of the run
  initial begin
    #20us;
    miscompares++;
    conclude();
  end

  // main sequence
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, assert_req} = '0;
    rst = 1'b1;
    repeat (20) @(negedge clk_sys);
    cmp("oe_n_in_reset", 12'hfff, oen12);
    rst = 1'b0;
    @(negedge clk_sys);
    cmp("oe_n_after_reset", 12'hfff, oen12);
    foreach (rows[i]) run_row(rows[i]);
    rd(OFS_CFG_A, 8'hbe);
    rd(OFS_CFG_B, 8'he2);
    wr(OFS_CFG_D, 8'hff);
    rd(OFS_CFG_D, 8'h3f);
    wr(8'h23, 8'hff);
    rd(8'h23, 8'h00);
    // second reset in mid-run clears the bytes and releases every line
    @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    cmp("oe_n_mid_reset", 12'hfff, oen12);
    rst = 1'b0;
    rd(OFS_CFG_A, 8'h00);
    cmp("level_after_reset", ~assert_req, lvl12);
    conclude();
  end
endmodule // tb_enable_output_config_decode
